// ===== rtl/tsb_regs.vh
// Constants for the tape slave bus stop sequencer.
// Assumes a single 50 MHz system clock.
`ifndef TSB_REGS_VH
`define TSB_REGS_VH

// System clock rate
`define TSB_CLK_MHZ 50

// Settle time of the preset on the read lines, in ns
`define TSB_FETCH_NS 1000
`define TSB_FETCH_CYC ((`TSB_FETCH_NS * `TSB_CLK_MHZ) / 1000)
`define TSB_FETCH_W 6

// Motion delay counter layout
`define TSB_CNT_W 16
`define TSB_BIT_GATE 13
`define TSB_BIT_HOLD 14
`define TSB_BIT_TOP 15
`define TSB_START_PRESET 13'h1F00

// Prescaler phases
`define TSB_PRE_START 2'h2
`define TSB_PRE_EMIT 2'h3

// Write path
`define TSB_DATA_W 9
`define TSB_FIFO_W 10
`define TSB_FIFO_DEPTH 4
`define TSB_FIFO_AW 2

// Status lines
`define TSB_STAT_W 8

`endif

// ===== rtl/quarter_prescaler.v
// Divide-by-four prescaler on bus clock ticks.
// Assumes tick_in is a one-cycle pulse per bus clock edge.
`timescale 1ns/1ps
`include "tsb_regs.vh"

module quarter_prescaler
(
   input wire clk_in,
   input wire rst_n_in,
   input wire tick_in,
   input wire run_in,
   output wire pulse_out
);

reg [1:0] phase_r;

// First pulse after two ticks, then every four
always @(posedge clk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
      phase_r <= `TSB_PRE_START;
   else if (!run_in)
      phase_r <= `TSB_PRE_START;
   else if (tick_in)
      phase_r <= phase_r + 2'h1;
end

assign pulse_out = run_in & tick_in & (phase_r == `TSB_PRE_EMIT);

endmodule

// ===== rtl/char_fifo.v
// Small FIFO of write characters.
// Assumes push only with in_ready_out high, pop only with out_valid_out high.
`timescale 1ns/1ps

module char_fifo
#(
   parameter WIDTH = 10,
   parameter DEPTH = 4,
   parameter AW = 2
)
(
   input wire clk_in,
   input wire rst_n_in,
   input wire in_valid_in,
   input wire [WIDTH-1:0] in_data_in,
   output wire in_ready_out,
   output wire out_valid_out,
   output wire [WIDTH-1:0] out_data_out,
   input wire out_ready_in
);

reg [WIDTH-1:0] mem_r [0:DEPTH-1];
reg [AW-1:0] wr_ptr_r;
reg [AW-1:0] rd_ptr_r;
reg [AW:0] count_r;
wire push;
wire pop;
wire [AW:0] depth_w;

assign depth_w = DEPTH[AW:0];
assign in_ready_out = (count_r != depth_w);
assign out_valid_out = (count_r != {(AW+1){1'b0}});
assign out_data_out = mem_r[rd_ptr_r];
assign push = in_valid_in & in_ready_out;
assign pop = out_ready_in & out_valid_out;

// Storage
always @(posedge clk_in)
begin
   if (push)
      mem_r[wr_ptr_r] <= in_data_in;
end

// Pointers and fill level
always @(posedge clk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
   begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
   end
   else
   begin
      if (push)
         wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
         rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
         count_r <= count_r + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
         count_r <= count_r - {{AW{1'b0}}, 1'b1};
   end
end

endmodule

// ===== rtl/tape_stop_sequencer.v
// Controller-side slave bus logic: command issue, motion delay counter,
// drive stop sequence, write character path and read capture.
// Assumes every transport input is synchronous to CLOCK_IN.
`timescale 1ns/1ps
`include "tsb_regs.vh"

module tape_stop_sequencer
(
   input wire CLOCK_IN,
   input wire RST_N_IN,
   input wire [2:0] UNIT_SEL_IN,
   input wire AHEAD_IN,
   input wire BACKWARD_IN,
   input wire REWIND_IN,
   input wire WRITE_EN_IN,
   input wire [1:0] PACKING_IN,
   input wire CMD_GO_IN,
   input wire READ_DONE_PULSE_IN,
   input wire [`TSB_DATA_W-1:0] WR_DATA_IN,
   input wire WR_LAST_IN,
   input wire WR_VALID_IN,
   output wire WR_READY_OUT,
   input wire BUS_CLOCK_IN,
   input wire TAPE_CHAR_CLOCK_IN,
   input wire [7:0] RECEIVED_READ_LINES_IN,
   input wire RECEIVED_READ_PARITY_IN,
   input wire READ_CHAR_STROBE_IN,
   input wire [`TSB_STAT_W-1:0] TRANSPORT_STATUS_IN,
   output wire [2:0] UNIT_SELECT_OUT,
   output wire AHEAD_CMD_OUT,
   output wire BACKWARD_CMD_OUT,
   output wire REWIND_CMD_OUT,
   output wire WRITE_ENABLE_CMD_OUT,
   output wire COMMAND_LATCH_PULSE_OUT,
   output wire [1:0] TAPE_PACKING_SELECT_OUT,
   output wire BUS_STOP_OUT,
   output wire PRESET_FETCH_ENABLE_OUT,
   output wire SPEED_UP_HOLD_OUT,
   output wire [`TSB_DATA_W-1:0] WRITE_DATA_LINES_OUT,
   output wire WRITE_CHAR_PULSE_OUT,
   output wire PARITY_CHAR_FLAG_OUT,
   output wire MOTION_ACTIVE_OUT,
   output wire READ_IN_PROGRESS_OUT,
   output wire [`TSB_DATA_W-1:0] READ_DATA_OUT,
   output wire READ_STROBE_OUT,
   output wire [`TSB_STAT_W-1:0] STATUS_OUT
);

// Motion states
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_MOVE = 4'h2;
localparam [3:0] ST_FETCH = 4'h4;
localparam [3:0] ST_COAST = 4'h8;

// Counter word for the start of motion
function [`TSB_CNT_W-1:0] start_word;
   input [12:0] preset;
   begin
      start_word = {2'b00, 1'b1, preset};
   end
endfunction

// Counter word for the stop load
function [`TSB_CNT_W-1:0] stop_word;
   input keep;
   input parity;
   input [7:0] lines;
   begin
      stop_word = {keep, keep, 1'b1, 4'h0, parity, lines};
   end
endfunction

reg [3:0] state_r;
reg [3:0] state_nxt;
reg [`TSB_CNT_W-1:0] cnt_r;
reg [`TSB_CNT_W-1:0] cnt_nxt;
reg [`TSB_FETCH_W-1:0] fetch_cnt_r;
reg [`TSB_FETCH_W-1:0] fetch_cnt_nxt;
reg [2:0] unit_r;
reg ahead_r;
reg backward_r;
reg rewind_r;
reg wr_cmd_r;
reg [1:0] packing_r;
reg latch_pulse_r;
reg hold_prev_r;
reg bus_clk_prev_r;
reg wclk_prev_r;
reg strobe_prev_r;
reg [`TSB_DATA_W-1:0] wdata_r;
reg flag_r;
reg pend_r;
reg char_pulse_r;
reg [`TSB_DATA_W-1:0] rdata_r;
reg rd_strobe_r;
reg [`TSB_STAT_W-1:0] status_r;

wire go_take;
wire go_motion;
wire hold;
wire hold_rise;
wire bus_tick;
wire wclk_tick;
wire rd_tick;
wire delay_pulse;
wire count_run;
wire fifo_valid;
wire [`TSB_FIFO_W-1:0] fifo_data;
wire drain;
wire reading;
wire [31:0] fetch_full;

assign fetch_full = `TSB_FETCH_CYC;

// Commands only taken while no motion is under way
assign go_take = CMD_GO_IN & (state_r == ST_IDLE);
assign go_motion = go_take & ~REWIND_IN;

// Hold is bit 14 inverted; low bit 14 means accelerating or stopped
assign hold = ~cnt_r[`TSB_BIT_HOLD];
assign hold_rise = hold & ~hold_prev_r;

// Edge detect on the transport clocks and strobe
assign bus_tick = BUS_CLOCK_IN & ~bus_clk_prev_r;
assign wclk_tick = TAPE_CHAR_CLOCK_IN & ~wclk_prev_r & ~hold;
assign rd_tick = READ_CHAR_STROBE_IN & ~strobe_prev_r;

// Prescaler runs only while bit 13 is set and no preset is loading
assign count_run = cnt_r[`TSB_BIT_GATE] & (state_r != ST_FETCH);

assign reading = cnt_r[`TSB_BIT_HOLD] ^ cnt_r[`TSB_BIT_TOP];

quarter_prescaler u_prescaler
(
   .clk_in(CLOCK_IN),
   .rst_n_in(RST_N_IN),
   .tick_in(bus_tick),
   .run_in(count_run),
   .pulse_out(delay_pulse)
);

// Write characters are taken from the FIFO on write clocks gated off by hold
assign drain = wclk_tick & fifo_valid & wr_cmd_r & (state_r != ST_IDLE);

char_fifo
#(
   .WIDTH(`TSB_FIFO_W),
   .DEPTH(`TSB_FIFO_DEPTH),
   .AW(`TSB_FIFO_AW)
)
u_fifo
(
   .clk_in(CLOCK_IN),
   .rst_n_in(RST_N_IN),
   .in_valid_in(WR_VALID_IN),
   .in_data_in({WR_LAST_IN, WR_DATA_IN}),
   .in_ready_out(WR_READY_OUT),
   .out_valid_out(fifo_valid),
   .out_data_out(fifo_data),
   .out_ready_in(drain)
);

// Motion state machine
always @*
begin
   state_nxt = state_r;
   fetch_cnt_nxt = fetch_cnt_r;
   case (state_r)
      ST_IDLE:
      begin
         if (go_motion)
            state_nxt = ST_MOVE;
      end
      ST_MOVE:
      begin
         if (READ_DONE_PULSE_IN)
         begin
            state_nxt = ST_FETCH;
            fetch_cnt_nxt = fetch_full[`TSB_FETCH_W-1:0];
         end
         else if (hold_rise)
            state_nxt = ST_IDLE;
      end
      ST_FETCH:
      begin
         if (fetch_cnt_r == {`TSB_FETCH_W{1'b0}})
            state_nxt = ST_COAST;
         else
            fetch_cnt_nxt = fetch_cnt_r - {{(`TSB_FETCH_W-1){1'b0}}, 1'b1};
      end
      ST_COAST:
      begin
         if (hold_rise)
            state_nxt = ST_IDLE;
      end
      default:
      begin
         state_nxt = ST_IDLE;
      end
   endcase
end

// Motion delay counter
always @*
begin
   cnt_nxt = cnt_r;
   if (go_motion)
      cnt_nxt = start_word(`TSB_START_PRESET);
   else if (state_r == ST_FETCH)
      cnt_nxt = stop_word(cnt_r[`TSB_BIT_HOLD], RECEIVED_READ_PARITY_IN,
         RECEIVED_READ_LINES_IN);
   else if (delay_pulse)
      cnt_nxt = cnt_r + 16'h0001;
end

always @(posedge CLOCK_IN or negedge RST_N_IN)
begin
   if (!RST_N_IN)
   begin
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      fetch_cnt_r <= 6'h00;
      hold_prev_r <= 1'b1;
   end
   else
   begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      fetch_cnt_r <= fetch_cnt_nxt;
      hold_prev_r <= hold;
   end
end

// Command lines and latch pulse
always @(posedge CLOCK_IN or negedge RST_N_IN)
begin
   if (!RST_N_IN)
   begin
      unit_r <= 3'h0;
      ahead_r <= 1'b0;
      backward_r <= 1'b0;
      rewind_r <= 1'b0;
      wr_cmd_r <= 1'b0;
      packing_r <= 2'h0;
      latch_pulse_r <= 1'b0;
   end
   else
   begin
      latch_pulse_r <= go_take;
      if (go_take)
      begin
         unit_r <= UNIT_SEL_IN;
         ahead_r <= AHEAD_IN;
         backward_r <= BACKWARD_IN;
         rewind_r <= REWIND_IN;
         wr_cmd_r <= WRITE_EN_IN;
         packing_r <= PACKING_IN;
      end
   end
end

// Edge history of transport inputs
always @(posedge CLOCK_IN or negedge RST_N_IN)
begin
   if (!RST_N_IN)
   begin
      bus_clk_prev_r <= 1'b0;
      wclk_prev_r <= 1'b0;
      strobe_prev_r <= 1'b0;
   end
   else
   begin
      bus_clk_prev_r <= BUS_CLOCK_IN;
      wclk_prev_r <= TAPE_CHAR_CLOCK_IN;
      strobe_prev_r <= READ_CHAR_STROBE_IN;
   end
end

// Write character path: data and flag one cycle ahead of the pulse
always @(posedge CLOCK_IN or negedge RST_N_IN)
begin
   if (!RST_N_IN)
   begin
      wdata_r <= 9'h000;
      flag_r <= 1'b0;
      pend_r <= 1'b0;
      char_pulse_r <= 1'b0;
   end
   else
   begin
      pend_r <= drain;
      char_pulse_r <= pend_r;
      if (drain)
      begin
         wdata_r <= fifo_data[`TSB_DATA_W-1:0];
         flag_r <= fifo_data[`TSB_FIFO_W-1];
      end
   end
end

// Read character capture during record transfer
always @(posedge CLOCK_IN or negedge RST_N_IN)
begin
   if (!RST_N_IN)
   begin
      rdata_r <= 9'h000;
      rd_strobe_r <= 1'b0;
      status_r <= 8'h00;
   end
   else
   begin
      status_r <= TRANSPORT_STATUS_IN;
      rd_strobe_r <= rd_tick & reading & (state_r == ST_MOVE);
      if (rd_tick & reading & (state_r == ST_MOVE))
         rdata_r <= {RECEIVED_READ_PARITY_IN, RECEIVED_READ_LINES_IN};
   end
end

assign UNIT_SELECT_OUT = unit_r;
assign AHEAD_CMD_OUT = ahead_r;
assign BACKWARD_CMD_OUT = backward_r;
assign REWIND_CMD_OUT = rewind_r;
assign WRITE_ENABLE_CMD_OUT = wr_cmd_r;
assign COMMAND_LATCH_PULSE_OUT = latch_pulse_r;
assign TAPE_PACKING_SELECT_OUT = packing_r;
assign BUS_STOP_OUT = (state_r == ST_IDLE);
assign PRESET_FETCH_ENABLE_OUT = (state_r == ST_FETCH);
assign SPEED_UP_HOLD_OUT = hold;
assign WRITE_DATA_LINES_OUT = wdata_r;
assign WRITE_CHAR_PULSE_OUT = char_pulse_r;
assign PARITY_CHAR_FLAG_OUT = flag_r;
assign MOTION_ACTIVE_OUT = (state_r != ST_IDLE);
assign READ_IN_PROGRESS_OUT = reading;
assign READ_DATA_OUT = rdata_r;
assign READ_STROBE_OUT = rd_strobe_r;
assign STATUS_OUT = status_r;

endmodule

// ===== sim/tss_asserts.sv
// Port checker for the tape stop sequencer.
// Assumes it is bound to tape_stop_sequencer.
`timescale 1ns/1ps
module tss_asserts
(
   input wire CLOCK_IN,
   input wire RST_N_IN,
   input wire CMD_GO_IN,
   input wire [2:0] UNIT_SEL_IN,
   input wire [1:0] PACKING_IN,
   input wire READ_DONE_PULSE_IN,
   input wire MOTION_ACTIVE_OUT,
   input wire COMMAND_LATCH_PULSE_OUT,
   input wire [2:0] UNIT_SELECT_OUT,
   input wire [1:0] TAPE_PACKING_SELECT_OUT,
   input wire PRESET_FETCH_ENABLE_OUT,
   input wire SPEED_UP_HOLD_OUT,
   input wire READ_IN_PROGRESS_OUT,
   input wire BUS_STOP_OUT,
   input wire WRITE_CHAR_PULSE_OUT
);
   default clocking @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   wire take = CMD_GO_IN & ~MOTION_ACTIVE_OUT;
   latch_pulse_a:
   assert property (take |=> COMMAND_LATCH_PULSE_OUT) else $error("no latch pulse");
   unit_sel_a:
   assert property (take |=> UNIT_SELECT_OUT == $past(UNIT_SEL_IN)) else $error("bad unit");
   packing_sel_a:
   assert property (take |=> TAPE_PACKING_SELECT_OUT == $past(PACKING_IN))
      else $error("bad density");
   accel_hold_a:
   assert property (take |=> SPEED_UP_HOLD_OUT [*8]) else $error("hold dropped early");
   fetch_start_a:
   assert property (READ_DONE_PULSE_IN && MOTION_ACTIVE_OUT && READ_IN_PROGRESS_OUT
      && !PRESET_FETCH_ENABLE_OUT |=> PRESET_FETCH_ENABLE_OUT) else $error("no fetch");
   rip_drop_a:
   assert property ($rose(PRESET_FETCH_ENABLE_OUT) |-> ##[1:2] !READ_IN_PROGRESS_OUT)
      else $error("read still in progress");
   reload_ones_a:
   assert property ($fell(PRESET_FETCH_ENABLE_OUT)
      |-> (!READ_IN_PROGRESS_OUT && !SPEED_UP_HOLD_OUT) [*8]) else $error("bad reload");
   hold_stop_a:
   assert property ($rose(SPEED_UP_HOLD_OUT) && MOTION_ACTIVE_OUT
      |=> BUS_STOP_OUT && !MOTION_ACTIVE_OUT) else $error("no stop");
   char_gate_a:
   assert property (WRITE_CHAR_PULSE_OUT |-> !$past(SPEED_UP_HOLD_OUT, 2))
      else $error("write during hold");
   cover property (take ##1 MOTION_ACTIVE_OUT);
   cover property ($rose(PRESET_FETCH_ENABLE_OUT));
   cover property (WRITE_CHAR_PULSE_OUT);
endmodule
bind tape_stop_sequencer tss_asserts i_chk (.*);

// ===== sim/tape_transport_model.sv
// Behavioural tape transport on the slave bus.
// Assumes the controller clock paces all transport timing.
`timescale 1ns/1ps
module tape_transport_model
#(
   parameter [8:0] PRESET = 9'h1FF
)
(
   input wire clk_in,
   input wire hold_in,
   input wire fetch_in,
   input wire stop_in,
   input wire latch_in,
   input wire move_in,
   input wire [8:0] tape_in,
   output reg bus_clock_out,
   output reg char_clock_out,
   output wire [8:0] read_out,
   output wire [7:0] status_out
);
   reg [1:0] ph_r;
   reg stopped_r;
   initial
   begin
      bus_clock_out = 1'b0;
      char_clock_out = 1'b0;
      ph_r = 2'h0;
      stopped_r = 1'b1;
   end
   always @(posedge clk_in)
   begin
      bus_clock_out <= ~bus_clock_out;
      ph_r <= ph_r + 2'h1;
      char_clock_out <= ~hold_in & ph_r[1];
      if (latch_in)
         stopped_r <= ~move_in;
      else if (stop_in)
         stopped_r <= 1'b1;
   end
   assign read_out = fetch_in ? PRESET : tape_in;
   assign status_out = {7'h2A, stopped_r};
endmodule

// ===== sim/tape_stop_sequencer_test.sv
// Self-checking bench for the tape stop sequencer.
// Assumes the transport model and the checker are compiled before it.
`timescale 1ns/1ps
module tape_stop_sequencer_test;
   reg clk, rst_n, go, done, wv, wl, strb;
   reg [2:0] us;
   reg [3:0] cmd;
   reg [1:0] pk;
   reg [8:0] wch, tape;
   wire [2:0] uso;
   wire [1:0] pko;
   wire [8:0] wdo, rdo, rl;
   wire [7:0] st, ts;
   wire ah, bk, rw, we, lp, bs, pf, hd, wp, pc, ma, rip, rs, wr, bc, cc;
   integer n_fail, n_compared, cyc, k, j;
   tape_stop_sequencer i_dut
   (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .UNIT_SEL_IN(us), .AHEAD_IN(cmd[3]),
      .BACKWARD_IN(cmd[2]), .REWIND_IN(cmd[1]), .WRITE_EN_IN(cmd[0]), .PACKING_IN(pk),
      .CMD_GO_IN(go), .READ_DONE_PULSE_IN(done), .WR_DATA_IN(wch), .WR_LAST_IN(wl),
      .WR_VALID_IN(wv), .WR_READY_OUT(wr), .BUS_CLOCK_IN(bc), .TAPE_CHAR_CLOCK_IN(cc),
      .RECEIVED_READ_LINES_IN(rl[7:0]), .RECEIVED_READ_PARITY_IN(rl[8]),
      .READ_CHAR_STROBE_IN(strb), .TRANSPORT_STATUS_IN(ts), .UNIT_SELECT_OUT(uso),
      .AHEAD_CMD_OUT(ah), .BACKWARD_CMD_OUT(bk), .REWIND_CMD_OUT(rw),
      .WRITE_ENABLE_CMD_OUT(we), .COMMAND_LATCH_PULSE_OUT(lp),
      .TAPE_PACKING_SELECT_OUT(pko), .BUS_STOP_OUT(bs), .PRESET_FETCH_ENABLE_OUT(pf),
      .SPEED_UP_HOLD_OUT(hd), .WRITE_DATA_LINES_OUT(wdo), .WRITE_CHAR_PULSE_OUT(wp),
      .PARITY_CHAR_FLAG_OUT(pc), .MOTION_ACTIVE_OUT(ma), .READ_IN_PROGRESS_OUT(rip),
      .READ_DATA_OUT(rdo), .READ_STROBE_OUT(rs), .STATUS_OUT(st)
   );
   tape_transport_model i_tape
   (
      .clk_in(clk), .hold_in(hd), .fetch_in(pf), .stop_in(bs), .latch_in(lp),
      .move_in(ah | bk), .tape_in(tape), .bus_clock_out(bc), .char_clock_out(cc),
      .read_out(rl), .status_out(ts)
   );
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task chk(input [15:0] got, input [15:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task print_verdict;
   begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 80000)
      begin
         n_fail = n_fail + 1;
         print_verdict;
      end
   end
   task t_reset;
   begin
      #1;
      chk({bs, hd, ma, wr, lp, pf}, 16'h0034);
   end
   endtask
   task t_rewind;
   begin
      @(posedge clk);
      us <= 3'h3;
      pk <= 2'h1;
      cmd <= 4'h2;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      chk({uso, pko, ah, bk, rw, we, lp, ma}, 16'h034A);
      @(posedge clk);
      #1;
      chk(lp, 0);
   end
   endtask
   task t_write;
   begin
      for (k = 0; k < 4; k = k + 1)
      begin
         @(posedge clk);
         wv <= 1'b1;
         wch <= {k[0], 8'h3C ^ k[7:0]};
         wl <= (k == 3);
      end
      @(posedge clk);
      wv <= 1'b0;
      us <= 3'h5;
      pk <= 2'h2;
      cmd <= 4'h9;
      go <= 1'b1;
      #1;
      chk(wr, 0);
      @(posedge clk);
      go <= 1'b0;
      #1;
      chk({uso, pko, ah, bk, rw, we, lp, ma}, 16'h05A7);
      j = 0;
      while (hd !== 1'b0 && j < 3000)
      begin
         @(posedge clk);
         #1;
         j = j + 1;
      end
      chk(j >= 2036 && j <= 2052, 1);
      chk({ma, bs, rip, st}, 16'h0554);
      for (k = 0; k < 4; k = k + 1)
      begin
         j = 0;
         while (wp !== 1'b1 && j < 40)
         begin
            @(posedge clk);
            #1;
            j = j + 1;
         end
         chk({wp, wdo}, {1'b1, k[0], 8'h3C ^ k[7:0]});
         chk(pc, k == 3);
         @(posedge clk);
         #1;
      end
      chk(wr, 1);
   end
   endtask
   task t_stop;
   begin
      @(posedge clk);
      tape <= 9'h0C3;
      strb <= 1'b1;
      @(posedge clk);
      strb <= 1'b0;
      #1;
      j = 0;
      while (rs !== 1'b1 && j < 8)
      begin
         @(posedge clk);
         #1;
         j = j + 1;
      end
      chk({rs, rdo}, 16'h02C3);
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      #1;
      chk(pf, 1);
      repeat (2) @(posedge clk);
      #1;
      chk(rip, 0);
      j = 0;
      while (bs !== 1'b1 && j < 70000)
      begin
         @(posedge clk);
         #1;
         j = j + 1;
      end
      chk(j >= 61478 && j <= 61512, 1);
      chk({ma, hd}, 16'h0001);
      repeat (2) @(posedge clk);
      #1;
      chk(st, 16'h0055);
   end
   endtask
   initial
   begin
      n_fail = 0;
      n_compared = 0;
      cyc = 0;
      {rst_n, go, done, wv, wl, strb, us, cmd, pk, wch, tape} = 0;
      repeat (12) @(posedge clk);
      t_reset;
      @(posedge clk);
      rst_n <= 1'b1;
      t_rewind;
      t_write;
      t_stop;
      print_verdict;
   end
endmodule
